/* rtl/mft_regs.svh */
// Register offsets, field positions, reset values and limits of the
// multi-function timer control block.
// Assumes it is included by the block's design files; it holds
// definitions only.
`ifndef MFT_REGS_SVH
`define MFT_REGS_SVH

// ***********************************************************
// Bus geometry and answers
// ***********************************************************
`define MFT_AXI_AW 8
`define MFT_RESP_OKAY 2'h0
`define MFT_RESP_SLVERR 2'h2

// ***********************************************************
// Register offsets (byte addresses)
// ***********************************************************
`define MFT_OFS_T1_CONFIG 8'h00
`define MFT_OFS_T2_IRQ 8'h04
`define MFT_OFS_T2_SETUP 8'h08
`define MFT_OFS_CMP_FIRST 8'h0C
`define MFT_OFS_CMP_SECOND 8'h10
`define MFT_OFS_RTC_COUNT 8'h14

// ***********************************************************
// timer_one_config fields
// ***********************************************************
`define MFT_T1_WRAP_BIT 7
`define MFT_T1_CAP_EDGE_BIT 6
`define MFT_T1_EV_EDGE_BIT 5
`define MFT_T1_PS_HI 4
`define MFT_T1_PS_LO 2
`define MFT_MODE_HI 1
`define MFT_MODE_LO 0

// ***********************************************************
// timer_two_irq_ctrl and timer_two_setup fields
// ***********************************************************
`define MFT_T2_CPF2_BIT 7
`define MFT_T2_CPF1_BIT 6
`define MFT_T2_CPIE_BIT 5
`define MFT_T2_CMF2_BIT 4
`define MFT_T2_CMF1_BIT 3
`define MFT_T2_CMIE_BIT 2
`define MFT_T2_OVF_BIT 1
`define MFT_T2_OVIE_BIT 0
`define MFT_T2_CAP_EDGE_BIT 6

// ***********************************************************
// Reset values and counter limits
// ***********************************************************
`define MFT_RST_BYTE 8'h00
`define MFT_RST_HALF 16'h0000
`define MFT_RTC_MAX 8'hFF
`define MFT_T2_MAX 16'hFFFF
`define MFT_PS_CNT_W 7

`endif

/* rtl/mft_pkg.sv */
// Types shared by the multi-function timer control block.
// Assumes nothing beyond a SystemVerilog compiler.
package mft_pkg;

   // Timer operating modes, in field order 00 to 11
   typedef enum logic [1:0] {
      MFT_MODE_SOFT,
      MFT_MODE_PWM,
      MFT_MODE_CAPCMP,
      MFT_MODE_EVENT
   } mft_mode_t;

   // Register selected by a bus address
   typedef enum logic [2:0] {
      MFT_SEL_T1_CONFIG,
      MFT_SEL_T2_IRQ,
      MFT_SEL_T2_SETUP,
      MFT_SEL_CMP_FIRST,
      MFT_SEL_CMP_SECOND,
      MFT_SEL_RTC_COUNT,
      MFT_SEL_NONE
   } mft_sel_t;

endpackage

/* rtl/mft_edge.sv */
// Edge detector with a selectable sense for one timer input pin.
// Assumes the pin is synchronous to clk_sys.
`timescale 1ns/1ns
`include "mft_regs.svh"

module mft_edge import mft_pkg::*; (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic pin,
   input wire logic rising_sel,
   output logic evt
);

   logic pin_q;

   // Previous pin level
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= pin;
      end
   end

   // One-cycle pulse on the chosen edge
   assign evt = rising_sel ? (pin & ~pin_q) : (~pin & pin_q);

endmodule

/* rtl/mft_prescale.sv */
// Power-of-two clock divider giving a one-cycle advance enable.
// Assumes the divide code is steady while a count is wanted exact.
`timescale 1ns/1ns
`include "mft_regs.svh"

module mft_prescale import mft_pkg::*; (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [2:0] prescale,
   output logic tick
);

   logic [`MFT_PS_CNT_W-1:0] div_cnt;
   logic [`MFT_PS_CNT_W-1:0] mask;

   // Free-running divide counter
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   // Low bits all ones once per 2**prescale cycles
   assign mask = `MFT_PS_CNT_W'((8'h01 << prescale) - 8'h01);
   assign tick = ((div_cnt & mask) == mask);

endmodule

/* rtl/mft_ctrl.sv */
// Control and status logic of two multi-function timers behind an
// AXI4-Lite register slave.
// Assumes all pins and datapath inputs are synchronous to clk_sys and
// that the second timer's counter datapath lives outside this block.
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "mft_regs.svh"

module mft_ctrl import mft_pkg::*; (
   input wire logic clk_sys,
   input wire logic rst_n,
   // AXI4-Lite slave
   input wire logic [`MFT_AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`MFT_AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Real-time counter
   input wire logic rt_counter_tick,
   // First timer pins and controls
   input wire logic t1_capture_one_pin,
   input wire logic t1_capture_two_pin,
   input wire logic t1_event_pin,
   output logic t1_count_adv,
   output logic t1_capture_one_evt,
   output logic t1_capture_two_evt,
   output logic [1:0] t1_mode_out,
   // Second timer pins and datapath
   input wire logic t2_capture_one_pin,
   input wire logic t2_capture_two_pin,
   input wire logic [15:0] t2_count,
   input wire logic t2_count_adv,
   input wire logic t2_cmp_second_active,
   output logic t2_capture_one_evt,
   output logic t2_capture_two_evt,
   output logic [15:0] compare_reg_first,
   output logic [15:0] compare_reg_second,
   output logic t2_irq
);

   // ***********************************************************
   // Helpers
   // ***********************************************************

   // Map a byte address to a register
   function automatic mft_sel_t mft_decode(
      input logic [`MFT_AXI_AW-1:0] addr);
      case (addr)
         `MFT_OFS_T1_CONFIG: mft_decode = MFT_SEL_T1_CONFIG;
         `MFT_OFS_T2_IRQ: mft_decode = MFT_SEL_T2_IRQ;
         `MFT_OFS_T2_SETUP: mft_decode = MFT_SEL_T2_SETUP;
         `MFT_OFS_CMP_FIRST: mft_decode = MFT_SEL_CMP_FIRST;
         `MFT_OFS_CMP_SECOND: mft_decode = MFT_SEL_CMP_SECOND;
         `MFT_OFS_RTC_COUNT: mft_decode = MFT_SEL_RTC_COUNT;
         default: mft_decode = MFT_SEL_NONE;
      endcase
   endfunction

   // Sticky flag update where a set beats a clear
   function automatic logic mft_sticky(input logic flag,
      input logic set, input logic clr);
      mft_sticky = set | (flag & ~clr);
   endfunction

   // ***********************************************************
   // Register state
   // ***********************************************************

   logic rt_counter_wrap_flag;
   logic timer_one_capture_edge;
   logic timer_one_event_edge;
   logic [2:0] timer_one_prescale;
   mft_mode_t timer_one_mode_sel;
   logic timer_two_capture_two_flag;
   logic timer_two_capture_one_flag;
   logic timer_two_capture_irq_en;
   logic timer_two_compare_two_flag;
   logic timer_two_compare_one_flag;
   logic timer_two_compare_irq_en;
   logic timer_two_wrap_flag;
   logic timer_two_wrap_irq_en;
   logic timer_two_capture_edge;
   mft_mode_t timer_two_mode_sel;
   logic [7:0] real_time_counter;

   // ***********************************************************
   // AXI4-Lite write channel
   // ***********************************************************

   logic aw_held;
   logic w_held;
   logic [`MFT_AXI_AW-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_do;
   mft_sel_t wr_sel;
   logic wr_lo;
   logic wr_hi;

   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign wr_do = aw_held & w_held & ~s_axi_bvalid;
   assign wr_sel = mft_decode(aw_addr_q);
   assign wr_lo = wr_do & w_strb_q[0];
   assign wr_hi = wr_do & w_strb_q[1];

   // Hold address and data until both are present
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_do) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_do) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write response, error for an unmapped or read-only address
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `MFT_RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         if (wr_sel == MFT_SEL_NONE || wr_sel == MFT_SEL_RTC_COUNT) begin
            s_axi_bresp <= `MFT_RESP_SLVERR;
         end else begin
            s_axi_bresp <= `MFT_RESP_OKAY;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ***********************************************************
   // AXI4-Lite read channel
   // ***********************************************************

   logic [31:0] rd_word;
   mft_sel_t rd_sel;

   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_sel = mft_decode(s_axi_araddr);

   // Read multiplexer, upper bits read as zero
   always_comb begin
      rd_word = '0;
      case (rd_sel)
         MFT_SEL_T1_CONFIG: begin
            rd_word[`MFT_T1_WRAP_BIT] = rt_counter_wrap_flag;
            rd_word[`MFT_T1_CAP_EDGE_BIT] = timer_one_capture_edge;
            rd_word[`MFT_T1_EV_EDGE_BIT] = timer_one_event_edge;
            rd_word[`MFT_T1_PS_HI:`MFT_T1_PS_LO] = timer_one_prescale;
            rd_word[`MFT_MODE_HI:`MFT_MODE_LO] = timer_one_mode_sel;
         end
         MFT_SEL_T2_IRQ: begin
            rd_word[`MFT_T2_CPF2_BIT] = timer_two_capture_two_flag;
            rd_word[`MFT_T2_CPF1_BIT] = timer_two_capture_one_flag;
            rd_word[`MFT_T2_CPIE_BIT] = timer_two_capture_irq_en;
            rd_word[`MFT_T2_CMF2_BIT] = timer_two_compare_two_flag;
            rd_word[`MFT_T2_CMF1_BIT] = timer_two_compare_one_flag;
            rd_word[`MFT_T2_CMIE_BIT] = timer_two_compare_irq_en;
            rd_word[`MFT_T2_OVF_BIT] = timer_two_wrap_flag;
            rd_word[`MFT_T2_OVIE_BIT] = timer_two_wrap_irq_en;
         end
         MFT_SEL_T2_SETUP: begin
            rd_word[`MFT_T2_CAP_EDGE_BIT] = timer_two_capture_edge;
            rd_word[`MFT_MODE_HI:`MFT_MODE_LO] = timer_two_mode_sel;
         end
         MFT_SEL_CMP_FIRST: rd_word[15:0] = compare_reg_first;
         MFT_SEL_CMP_SECOND: rd_word[15:0] = compare_reg_second;
         MFT_SEL_RTC_COUNT: rd_word[7:0] = real_time_counter;
         default: rd_word = '0;
      endcase
   end

   // Registered read answer
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `MFT_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         if (rd_sel == MFT_SEL_NONE) begin
            s_axi_rresp <= `MFT_RESP_SLVERR;
         end else begin
            s_axi_rresp <= `MFT_RESP_OKAY;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ***********************************************************
   // Pin edge detection
   // ***********************************************************

   logic [4:0] edge_pin;
   logic [4:0] edge_rise;
   logic [4:0] edge_evt;

   // Order: t1 cap1, t1 cap2, t1 event, t2 cap1, t2 cap2
   assign edge_pin = {t2_capture_two_pin, t2_capture_one_pin,
      t1_event_pin, t1_capture_two_pin, t1_capture_one_pin};
   assign edge_rise = {timer_two_capture_edge, timer_two_capture_edge,
      timer_one_event_edge, timer_one_capture_edge,
      timer_one_capture_edge};

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_edge
         mft_edge u_edge (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .pin(edge_pin[gi]),
            .rising_sel(edge_rise[gi]),
            .evt(edge_evt[gi])
         );
      end
   endgenerate

   // ***********************************************************
   // First timer configuration and controls
   // ***********************************************************

   logic ps_tick;
   logic wr_t1;
   logic rt_wrap_evt;

   assign wr_t1 = wr_lo & (wr_sel == MFT_SEL_T1_CONFIG);
   assign rt_wrap_evt = rt_counter_tick &
      (real_time_counter == `MFT_RTC_MAX);

   mft_prescale u_prescale (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .prescale(timer_one_prescale),
      .tick(ps_tick)
   );

   // Writable configuration fields
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         timer_one_capture_edge <= 1'b0;
         timer_one_event_edge <= 1'b0;
         timer_one_prescale <= '0;
         timer_one_mode_sel <= MFT_MODE_SOFT;
      end else if (wr_t1) begin
         timer_one_capture_edge <= w_data_q[`MFT_T1_CAP_EDGE_BIT];
         timer_one_event_edge <= w_data_q[`MFT_T1_EV_EDGE_BIT];
         timer_one_prescale <= w_data_q[`MFT_T1_PS_HI:`MFT_T1_PS_LO];
         timer_one_mode_sel <=
            mft_mode_t'(w_data_q[`MFT_MODE_HI:`MFT_MODE_LO]);
      end
   end

   // Real-time counter and its wrap flag
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         real_time_counter <= `MFT_RST_BYTE;
         rt_counter_wrap_flag <= 1'b0;
      end else begin
         if (rt_counter_tick) begin
            real_time_counter <= real_time_counter + 8'h01;
         end
         rt_counter_wrap_flag <= mft_sticky(rt_counter_wrap_flag,
            rt_wrap_evt, wr_t1 & ~w_data_q[`MFT_T1_WRAP_BIT]);
      end
   end

   // Advance and capture strobes to the first timer datapath
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         t1_count_adv <= 1'b0;
         t1_capture_one_evt <= 1'b0;
         t1_capture_two_evt <= 1'b0;
      end else begin
         case (timer_one_mode_sel)
            MFT_MODE_EVENT: t1_count_adv <= edge_evt[2];
            default: t1_count_adv <= ps_tick;
         endcase
         t1_capture_one_evt <= edge_evt[0] &
            (timer_one_mode_sel == MFT_MODE_CAPCMP);
         t1_capture_two_evt <= edge_evt[1] &
            (timer_one_mode_sel == MFT_MODE_CAPCMP);
      end
   end

   assign t1_mode_out = timer_one_mode_sel;

   // ***********************************************************
   // Second timer events
   // ***********************************************************

   logic t2_capmode;
   logic t2_cap1_evt;
   logic t2_cap2_evt;
   logic t2_hit_first;
   logic t2_hit_second;
   logic t2_wrap_evt;
   logic wr_t2;
   logic wr_setup;

   assign t2_capmode = (timer_two_mode_sel == MFT_MODE_CAPCMP);
   assign t2_cap1_evt = edge_evt[3] & t2_capmode;
   assign t2_cap2_evt = edge_evt[4] & t2_capmode;
   assign t2_hit_first = t2_count_adv & ~t2_cmp_second_active &
      (t2_count == compare_reg_first);
   assign t2_hit_second = t2_count_adv & t2_cmp_second_active &
      (t2_count == compare_reg_second);
   assign t2_wrap_evt = t2_count_adv & (t2_count == `MFT_T2_MAX);
   assign wr_t2 = wr_lo & (wr_sel == MFT_SEL_T2_IRQ);
   assign wr_setup = wr_lo & (wr_sel == MFT_SEL_T2_SETUP);

   // Interrupt enables and second timer setup
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         timer_two_capture_irq_en <= 1'b0;
         timer_two_compare_irq_en <= 1'b0;
         timer_two_wrap_irq_en <= 1'b0;
      end else if (wr_t2) begin
         timer_two_capture_irq_en <= w_data_q[`MFT_T2_CPIE_BIT];
         timer_two_compare_irq_en <= w_data_q[`MFT_T2_CMIE_BIT];
         timer_two_wrap_irq_en <= w_data_q[`MFT_T2_OVIE_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         timer_two_capture_edge <= 1'b0;
         timer_two_mode_sel <= MFT_MODE_SOFT;
      end else if (wr_setup) begin
         timer_two_capture_edge <= w_data_q[`MFT_T2_CAP_EDGE_BIT];
         timer_two_mode_sel <=
            mft_mode_t'(w_data_q[`MFT_MODE_HI:`MFT_MODE_LO]);
      end
   end

   // Sticky event flags, cleared by writing zero
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         timer_two_capture_two_flag <= 1'b0;
         timer_two_capture_one_flag <= 1'b0;
         timer_two_compare_two_flag <= 1'b0;
         timer_two_compare_one_flag <= 1'b0;
         timer_two_wrap_flag <= 1'b0;
      end else begin
         timer_two_capture_two_flag <= mft_sticky(
            timer_two_capture_two_flag, t2_cap2_evt,
            wr_t2 & ~w_data_q[`MFT_T2_CPF2_BIT]);
         timer_two_capture_one_flag <= mft_sticky(
            timer_two_capture_one_flag, t2_cap1_evt,
            wr_t2 & ~w_data_q[`MFT_T2_CPF1_BIT]);
         timer_two_compare_two_flag <= mft_sticky(
            timer_two_compare_two_flag, t2_hit_second,
            wr_t2 & ~w_data_q[`MFT_T2_CMF2_BIT]);
         timer_two_compare_one_flag <= mft_sticky(
            timer_two_compare_one_flag, t2_hit_first,
            wr_t2 & ~w_data_q[`MFT_T2_CMF1_BIT]);
         timer_two_wrap_flag <= mft_sticky(timer_two_wrap_flag,
            t2_wrap_evt, wr_t2 & ~w_data_q[`MFT_T2_OVF_BIT]);
      end
   end

   // Compare registers, byte lanes 0 and 1
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         compare_reg_first <= `MFT_RST_HALF;
         compare_reg_second <= `MFT_RST_HALF;
      end else begin
         if (wr_sel == MFT_SEL_CMP_FIRST) begin
            if (wr_lo) begin
               compare_reg_first[7:0] <= w_data_q[7:0];
            end
            if (wr_hi) begin
               compare_reg_first[15:8] <= w_data_q[15:8];
            end
         end
         if (wr_sel == MFT_SEL_CMP_SECOND) begin
            if (wr_lo) begin
               compare_reg_second[7:0] <= w_data_q[7:0];
            end
            if (wr_hi) begin
               compare_reg_second[15:8] <= w_data_q[15:8];
            end
         end
      end
   end

   // Capture strobes and interrupt pulse
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         t2_capture_one_evt <= 1'b0;
         t2_capture_two_evt <= 1'b0;
         t2_irq <= 1'b0;
      end else begin
         t2_capture_one_evt <= t2_cap1_evt;
         t2_capture_two_evt <= t2_cap2_evt;
         t2_irq <= (timer_two_capture_irq_en &
            (t2_cap1_evt | t2_cap2_evt)) |
            (timer_two_compare_irq_en &
            (t2_hit_first | t2_hit_second)) |
            (timer_two_wrap_irq_en & t2_wrap_evt);
      end
   end

endmodule

/* test/mft_pins.sv */
// Pin model: capture and event inputs of both timers.
// Assumes the bench sets the wanted levels in pin_lvl.
`timescale 1ns/1ns
module mft_pins (
   input wire logic clk_sys,
   input wire logic [4:0] pin_lvl,
   output logic t1_capture_one_pin = 1'h0,
   output logic t1_capture_two_pin = 1'h0,
   output logic t1_event_pin = 1'h0,
   output logic t2_capture_one_pin = 1'h0,
   output logic t2_capture_two_pin = 1'h0
);
   // Pins move just after the clock, like a synchronous source
   always @(posedge clk_sys)
      {t2_capture_two_pin, t2_capture_one_pin, t1_event_pin,
         t1_capture_two_pin, t1_capture_one_pin} <= pin_lvl;
endmodule

/* test/mft_ctrl_checker.sv */
// Port timing checks of the timer control block.
// Assumes binding to mft_ctrl, one clock domain.
`timescale 1ns/1ns
module mft_ctrl_checker (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic t1_capture_one_pin,
   input wire logic t1_capture_one_evt,
   input wire logic [1:0] t1_mode_out,
   input wire logic t2_capture_one_pin,
   input wire logic t2_capture_two_pin,
   input wire logic t2_count_adv,
   input wire logic t2_irq
);
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Write handshake: answer, release, blocking, reopening
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("no bvalid");
   wr_done_a: assert property (s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid) else $error("bvalid stuck");
   wr_block_a: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready) else $error("ready early");
   wr_reopen_a: assert property ($fell(s_axi_bvalid)
      |-> s_axi_awready && s_axi_wready) else $error("ready late");
   // Capture pulses follow a pin change, only in mode 10
   cap_edge_a: assert property (t1_capture_one_evt |->
      $past(t1_capture_one_pin) != $past(t1_capture_one_pin, 2))
      else $error("capture without edge");
   cap_mode_a: assert property (t1_capture_one_evt |->
      t1_mode_out == 2'h2) else $error("capture in wrong mode");
   cap_pulse_a: assert property (t1_capture_one_evt
      |=> !t1_capture_one_evt) else $error("capture too long");
   irq_cause_a: assert property (t2_irq |-> $past(t2_count_adv) ||
      $past(t2_capture_one_pin) != $past(t2_capture_one_pin, 2) ||
      $past(t2_capture_two_pin) != $past(t2_capture_two_pin, 2))
      else $error("irq without cause");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (t1_capture_one_evt);
   cover property (t2_irq);
endmodule
bind mft_ctrl mft_ctrl_checker u_mft_ctrl_checker (.*);

/* test/tb.sv */
// Self-checking bench of the timer control block.
// Assumes design, pin model and checker are compiled first.
`timescale 1ns/1ns
`include "mft_regs.svh"
module tb;
   localparam logic [7:0] A_CFG = `MFT_OFS_T1_CONFIG;
   localparam logic [7:0] A_IRQ = `MFT_OFS_T2_IRQ;
   logic clk_sys = 1'h0;
   logic rst_n, rt_counter_tick, t2_count_adv, t2_cmp_second_active;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, t2_irq, t1_count_adv;
   logic t1_capture_one_pin, t1_capture_two_pin, t1_event_pin;
   logic t2_capture_one_pin, t2_capture_two_pin, t1_capture_one_evt;
   logic t1_capture_two_evt, t2_capture_one_evt, t2_capture_two_evt;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, t1_mode_out;
   logic [15:0] t2_count, compare_reg_first, compare_reg_second;
   logic [4:0] pin_lvl;
   int bad_count, n_tests, cnt[6];
   wire [5:0] ev = {t2_irq, t2_capture_two_evt, t2_capture_one_evt,
      t1_count_adv, t1_capture_two_evt, t1_capture_one_evt};
   mft_ctrl u_mft_ctrl (.*);
   mft_pins u_mft_pins (.*);
   // Clock, pulse tallies, hang guard
   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) foreach (cnt[i]) cnt[i] <= cnt[i] + ev[i];
   initial #100000 end_sim(1'h1);
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic end_sim(input bit hang);
      bad_count += hang;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Bus write; each channel released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e,
         input logic [1:0] er = `MFT_RESP_OKAY);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      chk("read", {er, e}, {s_axi_rresp, s_axi_rdata[15:0]});
   endtask
   // Pin high then low; pulses counted as {rise, fall}
   task automatic edg(input int b, input logic [7:0] e);
      int c0, c1;
      @(posedge clk_sys); // Let an advance from the mode write land
      c0 = cnt[b];
      pin_lvl[b] <= 1'h1;
      repeat (6) @(posedge clk_sys);
      c1 = cnt[b];
      pin_lvl[b] <= 1'h0;
      repeat (6) @(posedge clk_sys);
      chk("edges", e, {4'(c1 - c0), 4'(cnt[b] - c1)});
   endtask
   task automatic hit(input logic [15:0] v, input logic s);
      t2_count <= v;
      t2_cmp_second_active <= s;
      t2_count_adv <= 1'h1;
      @(posedge clk_sys);
      t2_count_adv <= 1'h0;
      @(posedge clk_sys);
   endtask
   task automatic t_regs;
      rd(A_CFG, 16'h0000);
      wr(A_CFG, 32'h7E);
      rd(A_CFG, 16'h007E);
      wr(`MFT_OFS_RTC_COUNT, 32'h5);
      chk("bresp", `MFT_RESP_SLVERR, s_axi_bresp);
      rd(8'h1C, 16'h0000, `MFT_RESP_SLVERR);
      $display("t_regs done");
   endtask
   task automatic t_pre;
      int c;
      for (int k = 0; k < 8; k++) begin
         wr(A_CFG, 32'(k * 4));
         repeat (128) @(posedge clk_sys);
         c = cnt[2];
         repeat (256) @(posedge clk_sys);
         chk("ticks", 32'h100 >> k, cnt[2] - c);
      end
      $display("t_pre done");
   endtask
   task automatic t_cap;
      wr(A_CFG, 32'h42);
      edg(0, 8'h10);
      edg(1, 8'h10);
      wr(A_CFG, 32'h02);
      edg(0, 8'h01);
      wr(A_CFG, 32'h01);
      edg(1, 8'h00);
      wr(A_CFG, 32'h23);
      edg(2, 8'h10);
      wr(A_CFG, 32'h03);
      edg(2, 8'h01);
      $display("t_cap done");
   endtask
   task automatic t_flg;
      int c;
      wr(`MFT_OFS_T2_SETUP, 32'h42);
      wr(A_IRQ, 32'h25);
      c = cnt[5];
      edg(4, 8'h10);
      rd(A_IRQ, 16'h00A5);
      edg(3, 8'h10);
      rd(A_IRQ, 16'h00E5);
      hit(16'hFFFF, 1'h0);
      rd(A_IRQ, 16'h00E7);
      wr(`MFT_OFS_CMP_FIRST, 32'h1234);
      chk("cmp1", 32'h1234, compare_reg_first);
      hit(16'h1234, 1'h1);
      hit(16'h1234, 1'h0);
      rd(A_IRQ, 16'h00EF);
      wr(`MFT_OFS_CMP_SECOND, 32'h55);
      chk("cmp2", 32'h55, compare_reg_second);
      hit(16'h0055, 1'h1);
      rd(A_IRQ, 16'h00FF);
      chk("irq", 32'h5, cnt[5] - c);
      wr(A_IRQ, 32'h00);
      c = cnt[5];
      hit(16'hFFFF, 1'h0);
      rd(A_IRQ, 16'h0002);
      chk("irq", 32'h0, cnt[5] - c);
      // Clearing write and wrap in one cycle: the set must win
      fork
         wr(A_IRQ, 32'h00);
         begin
            @(posedge clk_sys);
            hit(16'hFFFF, 1'h0);
         end
      join
      rd(A_IRQ, 16'h0002);
      $display("t_flg done");
   endtask
   task automatic t_rtc;
      rt_counter_tick <= 1'h1;
      repeat (255) @(posedge clk_sys);
      rt_counter_tick <= 1'h0;
      rd(A_CFG, 16'h0003);
      rt_counter_tick <= 1'h1;
      @(posedge clk_sys);
      rt_counter_tick <= 1'h0;
      rd(A_CFG, 16'h0083);
      wr(A_CFG, 32'h03);
      rd(A_CFG, 16'h0003);
      $display("t_rtc done");
   endtask
   initial begin
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      {rt_counter_tick, t2_count_adv, t2_cmp_second_active} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, t2_count} = '0;
      {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
      pin_lvl = 5'h00;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'h1;
      @(posedge clk_sys);
      t_regs();
      t_pre();
      t_cap();
      t_flg();
      t_rtc();
      end_sim(1'h0);
   end
endmodule
